// File: rtl/tgrt_pkg.sv
package tgrt_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_BAR = 16;
    localparam int BAR_W = 4;
    localparam int SLM_SLOTS = 16;
    localparam int SLM_OFF_W = 4;
    localparam int SLM_SZ_W = 3;
    localparam int GID_W = 32;
    localparam int TCNT_W = 10;
    localparam int OUT_W = 10;
    localparam int CHAN_W = 5;
    localparam int EMASK_W = 32;

    // ----------------------------------------------------------------
    // Constants
    // ----------------------------------------------------------------
    localparam logic [2:0] SLM_SZ_MAX = 3'h4;
    localparam logic [EMASK_W-1:0] EMASK_ALL = 32'hffffffff;
    localparam logic [OUT_W-1:0] OUT_ONE = 10'h001;
    localparam logic [OUT_W-1:0] OUT_ZERO = 10'h000;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        TGRT_IDLE,
        TGRT_CHECK,
        TGRT_GW,
        TGRT_DISP
    } tgrt_state_t;

    typedef struct packed {
        logic [GID_W-1:0] group_id;
        logic slm_sw;
        logic [SLM_OFF_W-1:0] slm_off;
        logic [SLM_SZ_W-1:0] slm_size;
        logic [TCNT_W-1:0] thread_count;
        logic [CHAN_W-1:0] chan_count;
    } tgrt_cmd_t;

    typedef struct packed {
        logic [GID_W-1:0] group_id;
        logic [BAR_W-1:0] barrier_id;
        logic [SLM_OFF_W-1:0] slm_off;
        logic [EMASK_W-1:0] exec_mask;
    } tgrt_disp_t;

    typedef struct packed {
        logic [BAR_W-1:0] barrier_id;
        logic [TCNT_W-1:0] thread_count;
    } tgrt_gw_msg_t;

endpackage

// File: rtl/tgrt_tracker.sv
`timescale 1ns/1ps
// Functional notes
// - Stall command while requested offset still occupied
// - Mark offset used at start, free at finish
// - Associative barrier lookup across sixteen entries
// - Barrier programmed from per-group thread count
// - Unassigned group picks free barrier, messages gateway
// - Hold first dispatch until gateway accept arrives
// - Every dispatch carries the group's barrier id
// - Finished group returns barrier to pool
// - Payload holds 32-bit per-channel execution mask
// - Narrow dispatch uses only low mask bits
// - Expand 5-bit channel value into mask
// - Per-group outstanding counter; zero means complete
// - Power-of-two regions from 16-bit occupancy vector
module tgrt_tracker
    import tgrt_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic cmd_valid,
    input wire tgrt_cmd_t cmd,
    output logic cmd_ready,
    output logic gw_req_valid,
    output tgrt_gw_msg_t gw_req,
    input wire logic gw_accept,
    output logic disp_valid,
    output tgrt_disp_t disp,
    input wire logic disp_ready,
    input wire logic retire_valid,
    input wire logic [BAR_W-1:0] retire_barrier,
    output logic [NUM_BAR-1:0] bar_busy,
    output logic [SLM_SLOTS-1:0] slm_busy
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic [SLM_SLOTS-1:0] slm_region(input logic [SLM_OFF_W-1:0] off,
                                                        input logic [SLM_SZ_W-1:0] sz);
        logic [31:0] m;
        m = (32'h1 << (32'h1 << sz)) - 32'h1;
        m = m << off;
        return m[SLM_SLOTS-1:0];
    endfunction

    function automatic logic [EMASK_W-1:0] expand_mask(input logic [CHAN_W-1:0] n);
        return EMASK_ALL >> (5'h1f - n);
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    tgrt_state_t state_r;
    tgrt_cmd_t cmd_r;
    logic [NUM_BAR-1:0] valid_r;
    logic [GID_W-1:0] gid_r [NUM_BAR];
    logic [SLM_SLOTS-1:0] region_r [NUM_BAR];
    logic [OUT_W-1:0] out_cnt_r [NUM_BAR];
    logic [SLM_SLOTS-1:0] slm_used_r;
    logic [BAR_W-1:0] cur_bar_r;
    logic [SLM_OFF_W-1:0] cur_off_r;

    // ----------------------------------------------------------------
    // Lookup and allocation
    // ----------------------------------------------------------------
    logic hit;
    logic [BAR_W-1:0] hit_idx;
    logic free_found;
    logic [BAR_W-1:0] free_idx;
    logic slm_ok;
    logic [SLM_OFF_W-1:0] slm_pick;
    logic [SLM_SLOTS-1:0] slm_reg;
    logic disp_fire;
    logic [NUM_BAR-1:0] free_now;

    always_comb begin
        hit = 1'b0;
        hit_idx = '0;
        for (int i = 0; i < NUM_BAR; i++) begin
            if (!hit && valid_r[i] && gid_r[i] == cmd_r.group_id) begin
                hit = 1'b1;
                hit_idx = BAR_W'(i);
            end
        end
    end

    always_comb begin
        free_found = 1'b0;
        free_idx = '0;
        for (int i = 0; i < NUM_BAR; i++) begin
            if (!free_found && !valid_r[i]) begin
                free_found = 1'b1;
                free_idx = BAR_W'(i);
            end
        end
    end

    always_comb begin
        logic [SLM_SZ_W-1:0] sz;
        logic [SLM_SLOTS-1:0] r;
        sz = (cmd_r.slm_size > SLM_SZ_MAX) ? SLM_SZ_MAX : cmd_r.slm_size;
        r = '0;
        slm_ok = 1'b0;
        slm_pick = '0;
        slm_reg = '0;
        if (cmd_r.slm_sw) begin
            r = slm_region(cmd_r.slm_off, sz);
            slm_pick = cmd_r.slm_off;
            slm_reg = r;
            slm_ok = (slm_used_r & r) == '0;
        end else begin
            for (int i = 0; i < SLM_SLOTS; i++) begin
                r = slm_region(SLM_OFF_W'(i), sz);
                if (!slm_ok && (i % (1 << sz)) == 0 && (slm_used_r & r) == '0) begin
                    slm_ok = 1'b1;
                    slm_pick = SLM_OFF_W'(i);
                    slm_reg = r;
                end
            end
        end
    end

    assign disp_fire = disp_valid && disp_ready;

    always_comb begin
        for (int i = 0; i < NUM_BAR; i++) begin
            free_now[i] = retire_valid && retire_barrier == BAR_W'(i) && valid_r[i] &&
                          out_cnt_r[i] == OUT_ONE &&
                          !(disp_fire && cur_bar_r == BAR_W'(i));
        end
    end

    // ----------------------------------------------------------------
    // Sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_r <= TGRT_IDLE;
            cmd_r <= '0;
            cmd_ready <= 1'b0;
            cur_bar_r <= '0;
            cur_off_r <= '0;
        end else begin
            case (state_r)
                TGRT_IDLE: begin
                    cmd_ready <= 1'b1;
                    if (cmd_valid && cmd_ready) begin
                        cmd_r <= cmd;
                        cmd_ready <= 1'b0;
                        state_r <= TGRT_CHECK;
                    end
                end
                TGRT_CHECK: begin
                    if (hit) begin
                        cur_bar_r <= hit_idx;
                        state_r <= TGRT_DISP;
                    end else if (free_found && slm_ok) begin
                        cur_bar_r <= free_idx;
                        cur_off_r <= slm_pick;
                        state_r <= TGRT_GW;
                    end
                end
                TGRT_GW: begin
                    if (gw_accept) begin
                        state_r <= TGRT_DISP;
                    end
                end
                TGRT_DISP: begin
                    if (disp_fire) begin
                        state_r <= TGRT_IDLE;
                        cmd_ready <= 1'b1;
                    end
                end
                default: state_r <= TGRT_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Gateway message
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            gw_req_valid <= 1'b0;
            gw_req <= '0;
        end else if (state_r == TGRT_CHECK && !hit && free_found && slm_ok) begin
            gw_req_valid <= 1'b1;
            gw_req.barrier_id <= free_idx;
            gw_req.thread_count <= cmd_r.thread_count;
        end else if (gw_accept) begin
            gw_req_valid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Dispatch payload
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            disp_valid <= 1'b0;
            disp <= '0;
        end else if (disp_fire) begin
            disp_valid <= 1'b0;
        end else if ((state_r == TGRT_CHECK && hit) || (state_r == TGRT_GW && gw_accept)) begin
            disp_valid <= 1'b1;
            disp.group_id <= cmd_r.group_id;
            disp.barrier_id <= hit ? hit_idx : cur_bar_r;
            disp.slm_off <= hit ? region_off(hit_idx) : cur_off_r;
            disp.exec_mask <= expand_mask(cmd_r.chan_count);
        end
    end

    function automatic logic [SLM_OFF_W-1:0] region_off(input logic [BAR_W-1:0] b);
        logic [SLM_OFF_W-1:0] o;
        o = '0;
        for (int i = SLM_SLOTS - 1; i >= 0; i--) begin
            if (region_r[b][i]) begin
                o = SLM_OFF_W'(i);
            end
        end
        return o;
    endfunction

    // ----------------------------------------------------------------
    // Barrier table and outstanding counters
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            valid_r <= '0;
            for (int i = 0; i < NUM_BAR; i++) begin
                gid_r[i] <= '0;
                region_r[i] <= '0;
                out_cnt_r[i] <= OUT_ZERO;
            end
        end else begin
            for (int i = 0; i < NUM_BAR; i++) begin
                if (free_now[i]) begin
                    valid_r[i] <= 1'b0;
                end
                if (disp_fire && cur_bar_r == BAR_W'(i) &&
                    !(retire_valid && retire_barrier == BAR_W'(i))) begin
                    out_cnt_r[i] <= out_cnt_r[i] + OUT_ONE;
                end else if (!(disp_fire && cur_bar_r == BAR_W'(i)) && retire_valid &&
                             retire_barrier == BAR_W'(i) && out_cnt_r[i] != OUT_ZERO) begin
                    out_cnt_r[i] <= out_cnt_r[i] - OUT_ONE;
                end
            end
            if (state_r == TGRT_CHECK && !hit && free_found && slm_ok) begin
                valid_r[free_idx] <= 1'b1;
                gid_r[free_idx] <= cmd_r.group_id;
                region_r[free_idx] <= slm_reg;
                out_cnt_r[free_idx] <= OUT_ZERO;
            end
        end
    end

    // ----------------------------------------------------------------
    // Shared memory occupancy
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            slm_used_r <= '0;
        end else begin
            logic [SLM_SLOTS-1:0] v;
            v = slm_used_r;
            for (int i = 0; i < NUM_BAR; i++) begin
                if (free_now[i]) begin
                    v = v & ~region_r[i];
                end
            end
            if (state_r == TGRT_CHECK && !hit && free_found && slm_ok) begin
                v = v | slm_reg;
            end
            slm_used_r <= v;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bar_busy <= '0;
            slm_busy <= '0;
        end else begin
            bar_busy <= valid_r;
            slm_busy <= slm_used_r;
        end
    end

endmodule

// File: verification/tgrt_tracker_chk.sv
`timescale 1ns/1ps
module tgrt_tracker_chk
    import tgrt_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic cmd_valid,
    input wire tgrt_cmd_t cmd,
    input wire logic cmd_ready,
    input wire logic gw_req_valid,
    input wire tgrt_gw_msg_t gw_req,
    input wire logic gw_accept,
    input wire logic disp_valid,
    input wire tgrt_disp_t disp,
    input wire logic disp_ready,
    input wire logic retire_valid
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    tgrt_cmd_t cap_r;
    // Last taken command, the reference for what leaves
    always_ff @(posedge clk_sys) begin
        if (cmd_valid && cmd_ready) begin
            cap_r <= cmd;
        end
    end
    gw_hold_a: assert property (gw_req_valid && !gw_accept |=> gw_req_valid && $stable(gw_req))
        else $error("gateway message changed before accept");
    gw_block_a: assert property (gw_req_valid |-> !disp_valid)
        else $error("dispatch offered before gateway accept");
    accept_disp_a: assert property (gw_req_valid && gw_accept |=>
        disp_valid && disp.barrier_id == $past(gw_req.barrier_id))
        else $error("dispatch barrier differs from programmed barrier");
    disp_hold_a: assert property (disp_valid && !disp_ready |=> disp_valid && $stable(disp))
        else $error("dispatch changed while stalled");
    mask_a: assert property (disp_valid |-> disp.exec_mask == (EMASK_ALL >> (5'h1f - cap_r.chan_count)))
        else $error("execution mask wrong");
    msg_cnt_a: assert property ($rose(gw_req_valid) |-> gw_req.thread_count == cap_r.thread_count)
        else $error("gateway thread count wrong");
    one_cmd_a: assert property (cmd_valid && cmd_ready |=> !cmd_ready [*2])
        else $error("second command taken too early");
    slm_off_a: assert property (disp_valid && cap_r.slm_sw |-> disp.slm_off == cap_r.slm_off)
        else $error("dispatch offset differs from command offset");
    gid_a: assert property (disp_valid |-> disp.group_id == cap_r.group_id)
        else $error("dispatch group differs from command group");
    cover property (gw_req_valid && gw_accept);
    cover property (disp_valid && disp_ready);
    cover property (retire_valid);
endmodule

bind tgrt_tracker tgrt_tracker_chk tgrt_tracker_chk_i (.clk_sys(clk_sys), .srst(srst),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .gw_req_valid(gw_req_valid),
    .gw_req(gw_req), .gw_accept(gw_accept), .disp_valid(disp_valid), .disp(disp),
    .disp_ready(disp_ready), .retire_valid(retire_valid));

// File: verification/tgrt_gw_model.sv
`timescale 1ns/1ps
module tgrt_gw_model (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic gw_req_valid,
    input wire logic [3:0] gw_dly,
    output logic gw_accept
);
    logic [3:0] wait_r;
    // One accept pulse per message, after gw_dly idle cycles
    always_ff @(posedge clk_sys) begin
        if (srst || !gw_req_valid || gw_accept) begin
            wait_r <= 4'h0;
            gw_accept <= 1'b0;
        end else if (wait_r == gw_dly) begin
            gw_accept <= 1'b1;
        end else begin
            wait_r <= wait_r + 4'h1;
        end
    end
endmodule

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import tgrt_pkg::*;
    logic clk_sys, srst, cmd_valid, cmd_ready, gw_req_valid, gw_accept, disp_valid, disp_ready, retire_valid;
    tgrt_cmd_t cmd;
    tgrt_gw_msg_t gw_req, gw_got;
    tgrt_disp_t disp, d_got;
    logic [BAR_W-1:0] retire_barrier;
    logic [NUM_BAR-1:0] bar_busy;
    logic [SLM_SLOTS-1:0] slm_busy;
    logic [3:0] gw_dly;
    logic gw_seen;
    int error_cnt, check_count;
    tgrt_tracker tgrt_tracker_i (.clk_sys(clk_sys), .srst(srst), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .gw_req_valid(gw_req_valid), .gw_req(gw_req), .gw_accept(gw_accept),
        .disp_valid(disp_valid), .disp(disp), .disp_ready(disp_ready), .retire_valid(retire_valid),
        .retire_barrier(retire_barrier), .bar_busy(bar_busy), .slm_busy(slm_busy));
    tgrt_gw_model tgrt_gw_model_i (.clk_sys(clk_sys), .srst(srst), .gw_req_valid(gw_req_valid),
        .gw_dly(gw_dly), .gw_accept(gw_accept));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic finish_test();
        $display("errors=%0d checks=%0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic hang();
        error_cnt++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        finish_test();
    endtask
    task automatic send(input logic [31:0] gid, input logic sw, input logic [3:0] off, input logic [2:0] sz,
                        input logic [9:0] tc, input logic [4:0] ch);
        int n;
        n = 0;
        cmd_valid = 1'b1;
        cmd = '{gid, sw, off, sz, tc, ch};
        // Ready is looked at on the falling edge, where it has settled
        while (cmd_ready !== 1'b1 && n < 50) begin
            n++;
            @(negedge clk_sys);
        end
        if (n >= 50) hang();
        @(negedge clk_sys);
        cmd_valid = 1'b0;
    endtask
    task automatic wait_disp();
        int n;
        n = 0;
        gw_seen = 1'b0;
        while (disp_valid !== 1'b1 && n < 200) begin
            @(negedge clk_sys);
            if (gw_req_valid === 1'b1 && gw_seen === 1'b0) begin
                gw_seen = 1'b1;
                gw_got = gw_req;
            end
            n++;
        end
        if (n >= 200) hang();
        d_got = disp;
        disp_ready = 1'b1;
        @(negedge clk_sys);
        disp_ready = 1'b0;
    endtask
    task automatic retire(input logic [3:0] b);
        retire_valid = 1'b1;
        retire_barrier = b;
        @(negedge clk_sys);
        retire_valid = 1'b0;
        @(negedge clk_sys);
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_miss();
        gw_dly = 4'h3;
        send(32'h00000a11, 1'b1, 4'h0, 3'h0, 10'h005, 5'h07);
        wait_disp();
        chk(gw_seen, 1'b1);
        chk(d_got.group_id, 32'h00000a11);
        chk(gw_got.barrier_id, 4'h0);
        chk(gw_got.thread_count, 10'h005);
        chk(d_got.barrier_id, 4'h0);
        chk(d_got.exec_mask, 32'h000000ff);
        chk(d_got.slm_off, 4'h0);
    endtask
    task automatic t_hit();
        send(32'h00000a11, 1'b1, 4'h0, 3'h0, 10'h005, 5'h0f);
        wait_disp();
        chk(gw_seen, 1'b0);
        chk(d_got.barrier_id, 4'h0);
        chk(d_got.exec_mask, 32'h0000ffff);
    endtask
    task automatic t_new();
        gw_dly = 4'h0;
        send(32'h00000b22, 1'b1, 4'h1, 3'h0, 10'h003, 5'h1f);
        wait_disp();
        chk(gw_got.barrier_id, 4'h1);
        chk(d_got.exec_mask, 32'hffffffff);
        chk(d_got.slm_off, 4'h1);
        chk(slm_busy[1:0], 2'h3);
    endtask
    task automatic t_stall();
        send(32'h00000c33, 1'b1, 4'h0, 3'h0, 10'h007, 5'h00);
        repeat (10) @(negedge clk_sys);
        chk({gw_req_valid, disp_valid, cmd_ready}, 3'h0);
        retire(4'h0);
        retire(4'h0);
        wait_disp();
        chk(gw_got.barrier_id, 4'h0);
        chk(d_got.exec_mask, 32'h00000001);
        chk(d_got.slm_off, 4'h0);
    endtask
    task automatic t_retire();
        retire(4'h1);
        repeat (3) @(negedge clk_sys);
        chk(bar_busy[1:0], 2'h1);
    endtask
    task automatic t_hw();
        send(32'h00000d44, 1'b0, 4'h0, 3'h1, 10'h004, 5'h03);
        wait_disp();
        chk(gw_seen, 1'b1);
        chk(gw_got.barrier_id, 4'h1);
        chk(d_got.slm_off, 4'h2);
        chk(d_got.exec_mask, 32'h0000000f);
        chk(slm_busy[3:0], 4'hd);
    endtask
    initial begin
        error_cnt = 0;
        check_count = 0;
        srst = 1'b1;
        cmd_valid = 1'b0;
        cmd = '0;
        disp_ready = 1'b0;
        retire_valid = 1'b0;
        retire_barrier = 4'h0;
        gw_dly = 4'h0;
        repeat (5) @(negedge clk_sys);
        srst = 1'b0;
        t_miss();
        t_hit();
        t_new();
        t_stall();
        t_retire();
        t_hw();
        finish_test();
    end
endmodule
